// File: logic/mcdd_decoder.sv
/*
  Configuration data decoder: reads the processor module's serial configuration
  EEPROM over a two-wire link, decodes the image fields and shows them in
  APB registers.
  Assumes open-drain pads outside with pull-ups, no clock stretching by the
  EEPROM, and APB on the same core clock.
*/
// The register offsets and the APB interface to the registers were decided locally.
`timescale 1ns/1ps
module mcdd_decoder #(
  parameter int QTR_CYCLES = mcdd_pkg::QTR_CYCLES
) (
  input  wire logic        core_clk,
  input  wire logic        rst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        sda_i,
  output logic             sda_o,
  output logic             sda_oe,
  output logic             scl_o,
  output logic             scl_oe,
  input  wire logic [2:0]  module_id_lines,
  output logic             busy,
  output logic             decode_done,
  output logic             data_absent
);

  // Pin synchronisers; first stage read only by the second
  logic       sda_m_q;
  logic       sda_s_q;
  logic [2:0] id_m_q;
  logic [2:0] id_s_q;

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      sda_m_q <= 1'b1;
      sda_s_q <= 1'b1;
      id_m_q  <= 3'h0;
      id_s_q  <= 3'h0;
    end
    else
    begin
      sda_m_q <= sda_i;
      sda_s_q <= sda_m_q;
      id_m_q  <= module_id_lines;
      id_s_q  <= id_m_q;
    end
  end

  // Quarter-bit enable divider; the link clock is stepped by its tick in the sequencer
  logic [15:0] div_q;
  logic        tick;

  always_ff @(posedge core_clk)
  begin
    if (rst || div_q == 16'(QTR_CYCLES - 1))
      div_q <= 16'h0000;
    else
      div_q <= div_q + 16'h0001;
  end
  assign tick = (div_q == 16'(QTR_CYCLES - 1));

  // APB strobes
  logic wr_en;
  logic start_req;
  assign wr_en     = psel && penable && pwrite;
  assign start_req = wr_en && (paddr == mcdd_pkg::R_CTRL) && pwdata[mcdd_pkg::CTRL_START];

  // Link sequencer state
  mcdd_pkg::mcdd_state_t state_q;
  logic [1:0] phase_q;
  logic [3:0] bit_q;
  logic [8:0] tx_q;
  logic [8:0] rx_q;
  logic [6:0] idx_q;
  logic       scl_lvl_q;
  logic       sda_lvl_q;
  logic       done_q;
  logic       absent_q;
  logic       nack_q;
  logic       parallel_q;
  logic       head_ones_q;
  logic       bit_end;
  logic       byte_done;
  logic [7:0] rx_byte;

  assign bit_end   = tick && (phase_q == 2'h3);
  assign byte_done = bit_end && (state_q == mcdd_pkg::ST_READ)
                     && (bit_q == 4'(mcdd_pkg::BIT_LAST));
  assign rx_byte   = rx_q[8:1];

  // Sequencer: start, device write, word zero, restart, device read, bytes, stop
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      state_q    <= mcdd_pkg::ST_IDLE;
      phase_q    <= 2'h0;
      bit_q      <= 4'h0;
      tx_q       <= 9'h1FF;
      rx_q       <= 9'h000;
      idx_q      <= 7'h00;
      scl_lvl_q  <= 1'b1;
      sda_lvl_q  <= 1'b1;
      done_q     <= 1'b0;
      absent_q   <= 1'b0;
      nack_q     <= 1'b0;
      parallel_q <= 1'b0;
    end
    else
    begin
      case (state_q)
        mcdd_pkg::ST_IDLE:
        begin
          if (start_req)
          begin
            done_q   <= 1'b0;
            absent_q <= 1'b0;
            nack_q   <= 1'b0;
            // Parallel code in use: no serial image to fetch
            if (&id_s_q)
            begin
              parallel_q <= 1'b0;
              state_q    <= mcdd_pkg::ST_START;
              phase_q    <= 2'h0;
            end
            else
            begin
              parallel_q <= 1'b1;
              done_q     <= 1'b1;
            end
          end
        end
        mcdd_pkg::ST_START, mcdd_pkg::ST_RSTART:
        begin
          if (tick)
          begin
            phase_q <= phase_q + 2'h1;
            case (phase_q)
              2'h0:
              begin
                scl_lvl_q <= 1'b0;
                sda_lvl_q <= 1'b1;
              end
              2'h1: scl_lvl_q <= 1'b1;
              2'h2: sda_lvl_q <= 1'b0;  // Falling data with clock high
              default:
              begin
                scl_lvl_q <= 1'b0;
                bit_q     <= 4'h0;
                if (state_q == mcdd_pkg::ST_START)
                begin
                  state_q <= mcdd_pkg::ST_DEVW;
                  tx_q    <= {mcdd_pkg::EE_DEV_ADDR, mcdd_pkg::I2C_WR, 1'b1};
                end
                else
                begin
                  state_q <= mcdd_pkg::ST_DEVR;
                  tx_q    <= {mcdd_pkg::EE_DEV_ADDR, mcdd_pkg::I2C_RD, 1'b1};
                end
              end
            endcase
          end
        end
        mcdd_pkg::ST_DEVW, mcdd_pkg::ST_WADDR, mcdd_pkg::ST_DEVR, mcdd_pkg::ST_READ:
        begin
          if (tick)
          begin
            phase_q <= phase_q + 2'h1;
            case (phase_q)
              2'h0:
              begin
                scl_lvl_q <= 1'b0;
                sda_lvl_q <= tx_q[8];  // One releases the line
              end
              2'h1: scl_lvl_q <= 1'b1;
              2'h2: rx_q <= {rx_q[7:0], sda_s_q};
              default:
              begin
                scl_lvl_q <= 1'b0;
                tx_q      <= {tx_q[7:0], 1'b1};
                bit_q     <= bit_q + 4'h1;
                if (bit_q == 4'(mcdd_pkg::BIT_LAST))
                begin
                  bit_q <= 4'h0;
                  if (state_q == mcdd_pkg::ST_READ)
                  begin
                    // Sequential fetch from byte zero; last byte is not acked
                    if (idx_q == mcdd_pkg::B_LAST)
                      state_q <= mcdd_pkg::ST_STOP;
                    else
                    begin
                      idx_q <= idx_q + 7'h01;
                      tx_q  <= {mcdd_pkg::ALL_ONES, (idx_q + 7'h01) == mcdd_pkg::B_LAST};
                    end
                  end
                  else if (rx_q[0])
                  begin
                    nack_q  <= 1'b1;
                    state_q <= mcdd_pkg::ST_STOP;
                  end
                  else if (state_q == mcdd_pkg::ST_DEVW)
                  begin
                    state_q <= mcdd_pkg::ST_WADDR;
                    tx_q    <= {mcdd_pkg::EE_START_WORD, 1'b1};
                  end
                  else if (state_q == mcdd_pkg::ST_WADDR)
                    state_q <= mcdd_pkg::ST_RSTART;
                  else
                  begin
                    state_q <= mcdd_pkg::ST_READ;
                    idx_q   <= 7'h00;
                    tx_q    <= {mcdd_pkg::ALL_ONES, 1'b0};
                  end
                end
              end
            endcase
          end
        end
        mcdd_pkg::ST_STOP:
        begin
          if (tick)
          begin
            phase_q <= phase_q + 2'h1;
            case (phase_q)
              2'h0:
              begin
                scl_lvl_q <= 1'b0;
                sda_lvl_q <= 1'b0;
              end
              2'h1: scl_lvl_q <= 1'b1;
              2'h2: sda_lvl_q <= 1'b1;  // Rising data with clock high
              default:
              begin
                state_q  <= mcdd_pkg::ST_IDLE;
                done_q   <= 1'b1;
                absent_q <= !nack_q && head_ones_q;
              end
            endcase
          end
        end
        default: state_q <= mcdd_pkg::ST_IDLE;
      endcase
    end
  end

  // Open-drain pads: enable drives low, release floats high
  assign sda_o  = 1'b0;
  assign scl_o  = 1'b0;
  assign sda_oe = !sda_lvl_q;
  assign scl_oe = !scl_lvl_q;

  // Decoded fields
  logic [7:0]  byte_count_q;
  logic [7:0]  block_count_q;
  logic [7:0]  module_type_q;
  logic [15:0] data_width_q;
  logic [4:0]  voltage_id_code_q;
  logic [7:0]  signal_level_code_q;
  logic [7:0]  thermal_cal_low_q;
  logic [7:0]  thermal_cal_high_q;
  logic [7:0]  cache_kind_q;
  logic [15:0] cache_capacity_q;
  logic [15:0] cache_rate_q;
  logic        cache_clock_style_q;
  logic [7:0]  cache_hold_code_q;
  logic [7:0]  core_count_q;
  logic [7:0]  core_rate_q;
  logic [15:0] bus_rate_q;
  logic [31:0] maker_ticker_q;

  // Field capture; each byte lands at its image position
  always_ff @(posedge core_clk)
  begin
    if (rst || (start_req && state_q == mcdd_pkg::ST_IDLE))
    begin
      head_ones_q         <= 1'b1;
      byte_count_q        <= 8'h00;
      block_count_q       <= 8'h00;
      module_type_q       <= 8'hFF;
      data_width_q        <= 16'h0000;
      voltage_id_code_q   <= 5'h00;
      signal_level_code_q <= 8'h00;
      thermal_cal_low_q   <= 8'h00;
      thermal_cal_high_q  <= 8'h00;
      cache_kind_q        <= 8'h00;
      cache_capacity_q    <= 16'h0000;
      cache_rate_q        <= 16'h0000;
      cache_clock_style_q <= 1'b0;
      cache_hold_code_q   <= 8'h00;
      core_count_q        <= 8'h00;
      core_rate_q         <= 8'h00;
      bus_rate_q          <= 16'h0000;
      maker_ticker_q      <= 32'h0000_0000;
    end
    else if (byte_done)
    begin
      if (idx_q < mcdd_pkg::HEAD_LEN && rx_byte != mcdd_pkg::ALL_ONES)
        head_ones_q <= 1'b0;
      if (idx_q >= mcdd_pkg::B_TICKER && idx_q < mcdd_pkg::B_PART)
        maker_ticker_q[8*idx_q[1:0] +: 8] <= rx_byte;
      case (idx_q)
        mcdd_pkg::B_BYTE_COUNT: byte_count_q      <= rx_byte;
        mcdd_pkg::B_BLOCKS:     block_count_q     <= rx_byte;
        mcdd_pkg::B_TYPE:       module_type_q     <= rx_byte;
        mcdd_pkg::B_WIDTH_LO:   data_width_q[7:0] <= rx_byte;
        mcdd_pkg::B_WIDTH_HI:   data_width_q[15:8] <= rx_byte;
        mcdd_pkg::B_VOLT:       voltage_id_code_q <= rx_byte[4:0];
        mcdd_pkg::B_LEVEL:      signal_level_code_q <= rx_byte;
        mcdd_pkg::B_THERM_LO:   thermal_cal_low_q <= rx_byte;
        mcdd_pkg::B_THERM_HI:   thermal_cal_high_q <= rx_byte;
        mcdd_pkg::B_CKIND:      cache_kind_q      <= rx_byte;
        mcdd_pkg::B_CCAP_LO:    cache_capacity_q[7:0] <= rx_byte;
        mcdd_pkg::B_CCAP_HI:    cache_capacity_q[15:8] <= rx_byte;
        mcdd_pkg::B_CRATE_LO:   cache_rate_q[7:0] <= rx_byte;
        mcdd_pkg::B_CRATE_HI:   cache_rate_q[15:8] <= rx_byte;
        mcdd_pkg::B_CCLK:       cache_clock_style_q <= rx_byte[0];
        mcdd_pkg::B_HOLD:       cache_hold_code_q <= rx_byte;
        mcdd_pkg::B_CORES:      core_count_q      <= rx_byte;
        mcdd_pkg::B_CORE_RATE:  core_rate_q       <= rx_byte;
        mcdd_pkg::B_BUS_LO:     bus_rate_q[7:0]   <= rx_byte;
        mcdd_pkg::B_BUS_HI:     bus_rate_q[15:8]  <= rx_byte;
        default: ;  // Reserved and text bytes are not decoded here
      endcase
    end
  end

  // Part text store, one byte register per character
  logic [8*4*mcdd_pkg::PART_WORDS-1:0] part_flat;

  genvar gi;
  generate
    for (gi = 0; gi < 4 * mcdd_pkg::PART_WORDS; gi++)
    begin : g_part
      if (gi < mcdd_pkg::PART_LEN)
      begin : g_byte
        logic [7:0] part_text_q;
        always_ff @(posedge core_clk)
        begin
          if (rst || (start_req && state_q == mcdd_pkg::ST_IDLE))
            part_text_q <= 8'h00;
          else if (byte_done && idx_q == 7'(mcdd_pkg::B_PART + gi))
            part_text_q <= rx_byte;
        end
        assign part_flat[8*gi +: 8] = part_text_q;
      end
      else
      begin : g_pad
        assign part_flat[8*gi +: 8] = 8'h00;
      end
    end
  endgenerate

  // Value checks and decoded codes
  logic        count_ok;
  logic        blocks_ok;
  logic        type_cpu;
  logic        width_ok;
  logic        cache_valid;
  mcdd_pkg::mcdd_level_t level;
  logic [15:0] cap_vis;
  logic [15:0] rate_vis;
  logic        clk_vis;
  logic [7:0]  hold_vis;

  assign count_ok  = byte_count_q == mcdd_pkg::CNT_A || byte_count_q == mcdd_pkg::CNT_B
                     || byte_count_q == mcdd_pkg::CNT_C;
  assign blocks_ok = block_count_q == mcdd_pkg::BLK_A || block_count_q == mcdd_pkg::BLK_B
                     || block_count_q == mcdd_pkg::BLK_C;
  assign type_cpu  = module_type_q == mcdd_pkg::TYPE_CPU;
  assign width_ok  = data_width_q == mcdd_pkg::WIDTH_64
                     || data_width_q == mcdd_pkg::WIDTH_128;
  // Cache fields hidden when no cache is fitted
  assign cache_valid = cache_kind_q != mcdd_pkg::CKIND_NONE;
  assign cap_vis   = cache_valid ? cache_capacity_q : 16'h0000;
  assign rate_vis  = cache_valid ? cache_rate_q : 16'h0000;
  assign clk_vis   = cache_valid && cache_clock_style_q;
  assign hold_vis  = cache_valid ? cache_hold_code_q : 8'h00;

  // Signalling level map; any other code reads as none
  always_comb
  begin
    case (signal_level_code_q)
      8'h01:   level = mcdd_pkg::MCDD_LVL_LVTTL;
      8'h02:   level = mcdd_pkg::MCDD_LVL_SSTL;
      8'h03:   level = mcdd_pkg::MCDD_LVL_GTL;
      default: level = mcdd_pkg::MCDD_LVL_NONE;
    endcase
  end

  // APB read mux
  logic [31:0] rd_mux;
  logic        hit;

  always_comb
  begin
    rd_mux = 32'h0000_0000;
    hit    = 1'b1;
    if (paddr[11:5] == mcdd_pkg::R_PART_PAGE && paddr[4:2] < 3'(mcdd_pkg::PART_WORDS))
      rd_mux = part_flat[32*paddr[4:2] +: 32];
    else
    begin
      case (paddr)
        mcdd_pkg::R_CTRL:    rd_mux = 32'h0000_0000;  // Start is a write-only strobe
        mcdd_pkg::R_STATUS:
        begin
          rd_mux[mcdd_pkg::ST_BUSY]     = state_q != mcdd_pkg::ST_IDLE;
          rd_mux[mcdd_pkg::ST_DONE]     = done_q;
          rd_mux[mcdd_pkg::ST_ABSENT]   = absent_q;
          rd_mux[mcdd_pkg::ST_NACK]     = nack_q;
          rd_mux[mcdd_pkg::ST_PARALLEL] = parallel_q;
          rd_mux[mcdd_pkg::ST_ID_LSB +: 3] = id_s_q;
        end
        mcdd_pkg::R_INFO0:   rd_mux = {signal_level_code_q, module_type_q,
                                       block_count_q, byte_count_q};
        mcdd_pkg::R_INFO1:   rd_mux = {core_count_q, 3'h0, voltage_id_code_q, data_width_q};
        mcdd_pkg::R_THERM_L: rd_mux = {{24{thermal_cal_low_q[7]}}, thermal_cal_low_q};
        mcdd_pkg::R_THERM_H: rd_mux = {{24{thermal_cal_high_q[7]}}, thermal_cal_high_q};
        mcdd_pkg::R_CACHE0:  rd_mux = {rate_vis, cap_vis};
        mcdd_pkg::R_CACHE1:  rd_mux = {7'h00, cache_valid, hold_vis, 7'h00, clk_vis,
                                       cache_kind_q};
        mcdd_pkg::R_RATES:   rd_mux = {bus_rate_q, 8'h00, core_rate_q};
        // Decoded level shown beside the checks so every code is visible
        mcdd_pkg::R_VALID:   rd_mux = {25'h0, level, width_ok, type_cpu, blocks_ok, count_ok,
                                       level != mcdd_pkg::MCDD_LVL_NONE};
        mcdd_pkg::R_TICKER:  rd_mux = maker_ticker_q;
        default:             hit = 1'b0;
      endcase
    end
  end

  // Read data is registered in the setup phase, so the access phase never waits
  always_ff @(posedge core_clk)
  begin
    if (rst)
      prdata <= 32'h0000_0000;
    else if (psel && !penable)
      prdata <= hit ? rd_mux : 32'h0000_0000;
  end

  assign pready  = 1'b1;
  assign pslverr = psel && penable && !hit;

  assign busy        = state_q != mcdd_pkg::ST_IDLE;
  assign decode_done = done_q;
  assign data_absent = absent_q;

endmodule : mcdd_decoder

// File: logic/mcdd_pkg.sv
/*
  Constants for the module configuration data decoder: configuration image byte
  positions, permitted field values, APB register offsets, status bit positions
  and serial link timing.
  Assumes a 10 MHz core clock and a two-wire EEPROM with 7-bit device address.
*/
package mcdd_pkg;

  // Core clock and serial bit timing
  localparam int CLK_PERIOD_NS = 100;
  localparam int BIT_TIME_NS   = 10000;
  localparam int QTR_CYCLES    = BIT_TIME_NS / (4 * CLK_PERIOD_NS);

  // Serial link framing
  localparam logic [6:0] EE_DEV_ADDR = 7'h52;  // Second EEPROM slot
  localparam logic [7:0] EE_START_WORD = 8'h00;
  localparam logic       I2C_WR = 1'b0;
  localparam logic       I2C_RD = 1'b1;
  localparam logic [7:0] ALL_ONES = 8'hFF;
  localparam int         BIT_LAST = 8;

  // Image byte positions
  localparam logic [6:0] B_BYTE_COUNT = 7'h00;
  localparam logic [6:0] B_BLOCKS     = 7'h01;
  localparam logic [6:0] B_TYPE       = 7'h02;
  localparam logic [6:0] B_WIDTH_LO   = 7'h05;
  localparam logic [6:0] B_WIDTH_HI   = 7'h06;
  localparam logic [6:0] B_VOLT       = 7'h07;
  localparam logic [6:0] B_LEVEL      = 7'h08;
  localparam logic [6:0] B_THERM_LO   = 7'h09;
  localparam logic [6:0] B_THERM_HI   = 7'h0A;
  localparam logic [6:0] B_CKIND      = 7'h10;
  localparam logic [6:0] B_CCAP_LO    = 7'h11;
  localparam logic [6:0] B_CCAP_HI    = 7'h12;
  localparam logic [6:0] B_CRATE_LO   = 7'h13;
  localparam logic [6:0] B_CRATE_HI   = 7'h14;
  localparam logic [6:0] B_CCLK       = 7'h15;
  localparam logic [6:0] B_HOLD       = 7'h16;
  localparam logic [6:0] B_CORES      = 7'h20;
  localparam logic [6:0] B_CORE_RATE  = 7'h21;
  localparam logic [6:0] B_BUS_LO     = 7'h22;
  localparam logic [6:0] B_BUS_HI     = 7'h23;
  localparam logic [6:0] B_TICKER     = 7'h40;
  localparam int         TICKER_LEN   = 4;
  localparam logic [6:0] B_PART       = 7'h44;
  localparam int         PART_LEN     = 23;
  localparam int         PART_WORDS   = 6;
  localparam logic [6:0] B_LAST       = 7'h5A;
  localparam logic [6:0] HEAD_LEN     = 7'h04;

  // Permitted values
  localparam logic [7:0]  CNT_A = 8'h40;
  localparam logic [7:0]  CNT_B = 8'h80;
  localparam logic [7:0]  CNT_C = 8'hFF;
  localparam logic [7:0]  BLK_A = 8'h04;
  localparam logic [7:0]  BLK_B = 8'h08;
  localparam logic [7:0]  BLK_C = 8'h10;
  localparam logic [7:0]  TYPE_CPU = 8'h00;
  localparam logic [15:0] WIDTH_64  = 16'h0080;
  localparam logic [15:0] WIDTH_128 = 16'h0100;
  localparam logic [7:0]  CKIND_NONE = 8'h00;
  localparam logic [4:0]  VOLT_W = 5'h1F;

  typedef enum logic [1:0] {
    MCDD_LVL_NONE  = 2'b00,
    MCDD_LVL_LVTTL = 2'b01,
    MCDD_LVL_SSTL  = 2'b10,
    MCDD_LVL_GTL   = 2'b11
  } mcdd_level_t;

  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,
    ST_START  = 3'b001,
    ST_DEVW   = 3'b010,
    ST_WADDR  = 3'b011,
    ST_RSTART = 3'b100,
    ST_DEVR   = 3'b101,
    ST_READ   = 3'b110,
    ST_STOP   = 3'b111
  } mcdd_state_t;

  // APB register offsets (byte addresses)
  localparam logic [11:0] R_CTRL    = 12'h000;
  localparam logic [11:0] R_STATUS  = 12'h004;
  localparam logic [11:0] R_INFO0   = 12'h008;
  localparam logic [11:0] R_INFO1   = 12'h00C;
  localparam logic [11:0] R_THERM_L = 12'h010;
  localparam logic [11:0] R_THERM_H = 12'h014;
  localparam logic [11:0] R_CACHE0  = 12'h018;
  localparam logic [11:0] R_CACHE1  = 12'h01C;
  localparam logic [11:0] R_RATES   = 12'h020;
  localparam logic [11:0] R_VALID   = 12'h024;
  localparam logic [11:0] R_TICKER  = 12'h028;
  localparam logic [6:0]  R_PART_PAGE = 7'h02;  // 0x040..0x054

  // Bit positions
  localparam int CTRL_START   = 0;
  localparam int ST_BUSY      = 0;
  localparam int ST_DONE      = 1;
  localparam int ST_ABSENT    = 2;
  localparam int ST_NACK      = 3;
  localparam int ST_PARALLEL  = 4;
  localparam int ST_ID_LSB    = 8;

endpackage : mcdd_pkg

// File: verif/mcdd_decoder_test.sv
/*
  Bench for the decoder: EEPROM model on pulled-up wires, APB field reads.
  Assumes a short quarter-bit count so each fetch stays brief.
*/
`timescale 1ns/1ps
module mcdd_decoder_test;
  localparam logic [287:0] HEAD = 288'h012CC801_FFFFFFFFFFFFFFFFFF_1501014D020002_FFFFFFFFFF_05F603120100FFFF000880;
  localparam logic [63:0]  TEXT = 64'h3231515800434241;
  localparam logic [31:0]  EXP [0:9] = '{32'h03000880, 32'h01120100, 32'hFFFFFFF6, 32'h5,
    32'h014D0200, 32'h01150102, 32'h012C00C8, 32'h7F, 32'h00434241, 32'h32315158};
  logic core_clk = 1'h0, rst = 1'h1, psel = 1'h0, penable = 1'h0, pwrite = 1'h0, nak = 1'h0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [2:0]  module_id_lines = 3'h7;
  logic        pready, pslverr, serr, sda_oe, scl_oe, busy, decode_done, data_absent, ee_pull;
  logic [7:0]  img [0:127];
  int          fail_count = 0;
  int          checks = 0;
  wire         sda_w = !(sda_oe || ee_pull);
  always #50 core_clk = !core_clk;
  mcdd_decoder #(.QTR_CYCLES(3)) mcdd_decoder_i (
    .core_clk(core_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sda_i(sda_w), .sda_o(), .sda_oe(sda_oe), .scl_o(), .scl_oe(scl_oe),
    .module_id_lines(module_id_lines), .busy(busy), .decode_done(decode_done),
    .data_absent(data_absent));
  mcdd_eeprom mcdd_eeprom_i (.scl(!scl_oe), .sda(sda_w), .nak(nak), .image(img), .pull(ee_pull));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // One APB transfer, held until pready is seen high
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge core_clk);
    {psel, penable, pwrite, paddr, pwdata} <= {1'h1, 1'h0, w, a, d};
    @(posedge core_clk);
    penable <= 1'h1;
    do @(posedge core_clk); while (pready !== 1'h1);
    rd = prdata;
    serr = pslverr;
    {psel, penable} <= 2'h0;
  endtask : bus
  // Start, then wait for completion under a bound; busy rises one cycle late
  task automatic fetch(input logic [31:0] status);
    bus(1'h1, 12'h000, 32'h1);
    repeat (2) @(posedge core_clk);
    for (int k = 0; k < 20000 && !(decode_done === 1'h1 && busy === 1'h0); k++)
      @(posedge core_clk);
    chk(32'({data_absent, decode_done, busy}), 32'(status[2:0]));
    bus(1'h0, 12'h004, 32'h0);
    chk(rd, status);
  endtask : fetch
  task automatic t_full;
    fetch(32'h702);
    for (int i = 0; i < 10; i++)
    begin
      bus(1'h0, i < 9 ? 12'(8 + 4 * i) : 12'h040, 32'h0);
      chk(rd, EXP[i]);
    end
  endtask : t_full
  task automatic t_nocache;
    img[16] = 8'h00;
    img[8] = 8'h01;
    fetch(32'h702);
    bus(1'h0, 12'h018, 32'h0);
    chk(rd, 32'h0);
    bus(1'h0, 12'h01C, 32'h0);
    chk(rd, 32'h0);
    bus(1'h0, 12'h024, 32'h0);
    chk(rd, 32'h3F);
    img[16] = 8'h02;
  endtask : t_nocache
  task automatic t_refusals;
    nak <= 1'h1;
    fetch(32'h70A);
    nak <= 1'h0;
    {img[0], img[1], img[2]} = 24'hFFFFFF;
    fetch(32'h706);
    module_id_lines <= 3'h5;
    repeat (4) @(posedge core_clk);
    fetch(32'h512);
    bus(1'h1, 12'h030, 32'h1);
    chk(32'(serr), 32'h1);
    bus(1'h0, 12'h000, 32'h0);
    chk(rd, 32'h0);
    chk(32'(serr), 32'h0);
  endtask : t_refusals
  task automatic final_report;
    if (fail_count == 0 && checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : final_report
  // Image: reserved and trailing bytes all ones, unused text bytes zero
  initial
  begin
    for (int i = 0; i < 128; i++)
      img[i] = i < 36 ? HEAD[8*i +: 8] : i < 64 || i > 90 ? 8'hFF :
        i < 72 ? TEXT[8*(i-64) +: 8] : 8'h00;
    repeat (8) @(posedge core_clk);
    rst <= 1'h0;
    t_full();
    t_nocache();
    t_refusals();
    final_report();
  end
  // Hang guard, well beyond five short fetches
  initial
  begin
    repeat (60000) @(posedge core_clk);
    fail_count++;
    final_report();
  end
endmodule : mcdd_decoder_test

// File: verif/mcdd_eeprom.sv
/*
  Serial configuration EEPROM model: acks its address, reads from the word set.
  Assumes pulled-up open-drain wires resolved by the bench.
*/
`timescale 1ns/1ps
module mcdd_eeprom (
  input wire logic       scl,
  input wire logic       sda,
  input wire logic       nak,
  input wire logic [7:0] image [0:127],
  output logic           pull
);
  logic [7:0] sh, ptr;
  logic       act, rx, rd, first;
  int         n;
  initial pull = 1'h0;
  // Start resets framing; stop leaves the model deaf
  always @(negedge sda)
    if (scl)
    begin
      {act, rx, first, rd, pull} = 5'h1C;
      n = 0;
    end
  always @(posedge sda)
    if (scl)
      act = 1'h0;
  // Bits are taken while the clock is high
  always @(posedge scl)
    if (act)
    begin
      if (rx && n < 8)
        sh = {sh[6:0], sda};
      if (!rx && n == 8 && sda)
        act = 1'h0;
      n++;
    end
  // Drive changes only while the clock is low; released bits float to the pull-up
  always @(negedge scl)
    if (act)
    begin
      if (rx && n == 8)
      begin
        pull = !nak && (!first || sh[7:1] == mcdd_pkg::EE_DEV_ADDR);
        rd = first ? sh[0] : rd;
        ptr = first ? ptr : sh;
        first = 1'h0;
      end
      else if (n == 9)
      begin
        n = 0;
        rx = !rd;
        sh = image[ptr[6:0]];
        ptr = ptr + 8'(rd);
        pull = rd && !sh[7];
      end
      else
        pull = !rx && n < 8 && !sh[7 - n];
    end
endmodule : mcdd_eeprom

// File: verif/mcdd_properties.sv
/*
  Checker for the decoder's bus, link and status ports.
  Assumes it is bound onto the decoder and sees its ports only.
*/
`timescale 1ns/1ps
module mcdd_checker #(
  parameter int QTR_CYCLES = 25
) (
  input wire logic        core_clk,
  input wire logic        rst,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        scl_oe,
  input wire logic        sda_oe,
  input wire logic [2:0]  module_id_lines,
  input wire logic        busy,
  input wire logic        decode_done,
  input wire logic        data_absent
);
  logic [2:0] id_q1;
  logic [2:0] id_q2;
  wire        start_w = psel && penable && pwrite && paddr == 12'h000 && pwdata[0] && !busy;
  wire        id_hold = id_q1 == module_id_lines && id_q2 == module_id_lines;
  // Id history: a start is judged only on lines that have settled
  always_ff @(posedge core_clk)
  begin
    id_q1 <= module_id_lines;
    id_q2 <= id_q1;
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  reset_quiet_a: assert property (
    $fell(rst) |-> !(busy || decode_done || data_absent || scl_oe || sda_oe))
    else $error("not idle after reset");
  slave_error_a: assert property (psel && penable |-> pready
    && pslverr == (paddr > 12'h054 || (paddr > 12'h028 && paddr < 12'h040)))
    else $error("bus answer wrong");
  id_refuse_a: assert property (
    start_w && id_hold && module_id_lines != 3'h7 |=> decode_done && !busy)
    else $error("fetch despite id lines");
  fetch_begin_a: assert property (
    start_w && id_hold && module_id_lines == 3'h7 |-> ##[1:2] busy)
    else $error("fetch did not begin");
  flag_clear_a: assert property (
    $rose(busy) |-> ##1 !(decode_done || data_absent))
    else $error("flags kept on new fetch");
  done_follows_a: assert property (
    $fell(busy) && !$past(rst) |-> ##[0:2] decode_done)
    else $error("no done after fetch");
  done_sticky_a: assert property (
    decode_done && !start_w |=> decode_done)
    else $error("done dropped");
  link_idle_a: assert property (
    !busy [*3] |-> !scl_oe && !sda_oe)
    else $error("link held while idle");
endmodule : mcdd_checker

bind mcdd_decoder mcdd_checker #(.QTR_CYCLES(QTR_CYCLES)) mcdd_checker_i (
  .core_clk(core_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
  .scl_oe(scl_oe), .sda_oe(sda_oe), .module_id_lines(module_id_lines),
  .busy(busy), .decode_done(decode_done), .data_absent(data_absent));
